// file: logic/dcs_user_ports.sv
// credit grant, queue status and user interrupt ports of the dma engine
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// R1 - user holds credit fields stable from valid until valid and ready meet
// R2 - ready only when a grant can be taken; taken on valid and ready
// R3 - credit direction 0 selects host-to-card ring, 1 card-to-host
// R4 - each grant names its ring by an 11-bit queue number
// R5 - accepted 16-bit count adds that many fetchable descriptors
// R6 - per-ring balance; each fetch takes one; no fetch at zero
// R7 - status valid and fields hold until the user gives ready
// R8 - unused status port has its ready tied high by the user
// R9 - status carries the bypass bit of the queue context
// R10 - status direction 0 for host-to-card, 1 for card-to-host
// R11 - status type 0 for streaming, 1 for memory-mapped
// R12 - status carries 11-bit ring number and 3-bit port number
// R13 - available is credits when invalidated, else newly posted count
// R14 - invalidated flag set when the queue was invalidated
// R15 - status reports the queue enable state
// R16 - status reports whether the driver armed interrupts
// R17 - overrun bit set when producer index passes consumer index
// R18 - user holds request valid, vector, function until acknowledge
// R19 - request carries a 5-bit vector and an 8-bit function
// R20 - acknowledge pulses after sending; user waits for it
// R21 - fail pulses when a request is aborted before sending
// R22 - user requests at most eight vectors per function
// R23 - each accepted request gets exactly one ack or one fail
module dcs_user_ports
    import dcs_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic CREDIT_GRANT_VALID,
    output logic CREDIT_GRANT_READY,
    input wire logic CREDIT_GRANT_DIRECTION,
    input wire logic [10:0] CREDIT_GRANT_QUEUE,
    input wire logic [15:0] CREDIT_GRANT_COUNT,
    input wire logic FETCH_REQ_VALID,
    input wire dcs_ring_t FETCH_REQ_RING,
    output logic FETCH_GRANT,
    input wire logic STS_EVT_VALID,
    input wire dcs_event_t STS_EVT,
    output logic STS_EVT_READY,
    output logic QUEUE_STATUS_VALID,
    input wire logic QUEUE_STATUS_READY,
    output dcs_status_t QUEUE_STATUS,
    input wire logic USER_IRQ_REQUEST_VALID,
    input wire logic [4:0] USER_IRQ_VECTOR,
    input wire logic [7:0] USER_IRQ_FUNCTION,
    output logic USER_IRQ_ACKNOWLEDGE,
    output logic USER_IRQ_ABORT,
    output logic LINK_IRQ_VALID,
    output logic [4:0] LINK_IRQ_VECTOR,
    output logic [7:0] LINK_IRQ_FUNCTION,
    input wire logic LINK_IRQ_SENT,
    input wire logic LINK_IRQ_ABORTED,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // modulo-16-bit ring distance from b forward to a
    function automatic logic [15:0] ring_diff(input logic [15:0] a, input logic [15:0] b);
        ring_diff = a - b;
    endfunction

    // credit add that sticks at all ones instead of wrapping to a tiny balance
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        sat_add = sum[16] ? 16'hFFFF : sum[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state and credit balance memory

    dcs_state_t s;
    dcs_state_t n;
    logic [15:0] bal_mem [0:RING_N-1];
    logic mem_we;
    dcs_ring_t mem_addr;
    logic [15:0] mem_data;
    logic [15:0] fetch_bal;
    logic [15:0] hold_bal;
    logic [15:0] evt_bal;
    logic [15:0] probe_bal;
    logic fetch_ok;
    logic sts_load;
    logic [15:0] posted;
    logic overrun;
    dcs_ring_t evt_ring;

    assign evt_ring = {STS_EVT.direction, STS_EVT.queue};
    assign fetch_bal = bal_mem[FETCH_REQ_RING];
    assign hold_bal = bal_mem[s.hold_ring];
    assign evt_bal = bal_mem[evt_ring];
    assign probe_bal = bal_mem[s.probe];
    assign posted = ring_diff(STS_EVT.new_producer_index, STS_EVT.old_producer_index);
    // free slots are consumer minus old producer minus one; more posted is an overrun
    assign overrun = posted > ring_diff(ring_diff(STS_EVT.consumer_index,
        STS_EVT.old_producer_index), 16'h0001); // R17
    assign fetch_ok = s.init_done && s.ctrl[CTRL_FETCH_EN] && FETCH_REQ_VALID
        && (fetch_bal != 16'h0000); // R6
    assign sts_load = STS_EVT_VALID && s.sts_ready;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // one memory write port: sweep after reset, then fetch before pending grant
    always_comb
    begin
        n = s;
        n.fetch_grant = 1'b0;
        n.ack = 1'b0;
        n.fail = 1'b0;
        n.rdata = 32'h0000_0000;
        mem_we = 1'b0;
        mem_addr = s.init_idx;
        mem_data = 16'h0000;
        if (!s.init_done)
        begin
            // balances have no reset, so every ring is zeroed before grants open
            mem_we = 1'b1;
            n.init_idx = s.init_idx + 12'h001;
            if (&s.init_idx)
            begin
                n.init_done = 1'b1;
            end
        end
        else if (fetch_ok)
        begin
            n.fetch_grant = 1'b1;
            mem_we = 1'b1;
            mem_addr = FETCH_REQ_RING;
            mem_data = fetch_bal - 16'h0001; // R6
            if (s.hold_v && (s.hold_ring == FETCH_REQ_RING))
            begin
                mem_data = sat_add(fetch_bal, s.hold_cnt) - 16'h0001; // R5
                n.hold_v = 1'b0;
            end
        end
        else if (s.hold_v)
        begin
            mem_we = 1'b1;
            mem_addr = s.hold_ring;
            mem_data = sat_add(hold_bal, s.hold_cnt); // R5
            n.hold_v = 1'b0;
        end
        // grant is parked until the write port is free
        if (CREDIT_GRANT_VALID && s.grant_ready)
        begin
            n.hold_v = 1'b1; // R2
            n.hold_ring = {CREDIT_GRANT_DIRECTION, CREDIT_GRANT_QUEUE}; // R3 R4
            n.hold_cnt = CREDIT_GRANT_COUNT;
        end
        n.grant_ready = n.init_done && !n.hold_v; // R2

        // status slot: one update in flight, refilled only after the handshake
        if (sts_load)
        begin
            n.sts_valid = 1'b1;
            n.sts.queue_status_bypass_flag = STS_EVT.bypass; // R9
            n.sts.queue_status_direction = STS_EVT.direction; // R10
            n.sts.queue_status_memory_mapped = STS_EVT.memory_mapped; // R11
            n.sts.queue_status_queue = STS_EVT.queue; // R12
            n.sts.queue_status_port = STS_EVT.port; // R12
            n.sts.queue_status_available = STS_EVT.invalidated ? evt_bal : posted; // R13
            n.sts.queue_status_invalidated = STS_EVT.invalidated; // R14
            n.sts.queue_status_enabled = STS_EVT.enabled; // R15
            n.sts.queue_status_irq_armed = STS_EVT.irq_armed; // R16
            n.sts.queue_status_overrun = overrun; // R17
        end
        else if (s.sts_valid && QUEUE_STATUS_READY)
        begin
            n.sts_valid = 1'b0; // R7
        end
        n.sts_ready = !n.sts_valid;

        // interrupt request sequencer
        case (s.irq)
            IRQ_IDLE:
            begin
                if (USER_IRQ_REQUEST_VALID)
                begin
                    if ((USER_IRQ_VECTOR >= VEC_LIMIT) || !s.ctrl[CTRL_IRQ_EN])
                    begin
                        n.fail = 1'b1; // R21
                        n.irq = IRQ_RESP;
                    end
                    else
                    begin
                        n.link_valid = 1'b1;
                        n.link_vec = USER_IRQ_VECTOR; // R19
                        n.link_fnc = USER_IRQ_FUNCTION; // R19
                        n.irq = IRQ_LINK;
                    end
                end
            end
            IRQ_LINK:
            begin
                // sent wins if the link reports both, so only one answer goes out
                if (LINK_IRQ_SENT)
                begin
                    n.ack = 1'b1; // R20 R23
                    n.link_valid = 1'b0;
                    n.irq = IRQ_RESP;
                end
                else if (LINK_IRQ_ABORTED)
                begin
                    n.fail = 1'b1; // R21 R23
                    n.link_valid = 1'b0;
                    n.irq = IRQ_RESP;
                end
            end
            IRQ_RESP:
            begin
                // the user still shows valid during the answer cycle; skip it
                n.irq = IRQ_IDLE;
            end
            default:
            begin
                n.irq = IRQ_IDLE;
                n.link_valid = 1'b0;
            end
        endcase
        // register port
        if (REG_WR)
        begin
            case (REG_ADDR)
                REG_CTRL: n.ctrl = REG_WDATA[1:0];
                REG_PROBE: n.probe = REG_WDATA[11:0];
                REG_STATS:
                begin
                    n.ack_cnt = 16'h0000;
                    n.fail_cnt = 16'h0000;
                end
                default: n.ctrl = s.ctrl;
            endcase
        end
        // counted after the clear, so an answer in the clearing cycle is not lost
        if (n.ack)
        begin
            n.ack_cnt = n.ack_cnt + 16'h0001;
        end
        if (n.fail)
        begin
            n.fail_cnt = n.fail_cnt + 16'h0001;
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                REG_CTRL: n.rdata = {30'h0000_0000, s.ctrl};
                REG_PROBE: n.rdata = {20'h0_0000, s.probe};
                REG_BALANCE: n.rdata = {16'h0000, probe_bal};
                REG_STATS: n.rdata = {s.fail_cnt, s.ack_cnt};
                REG_STATE: n.rdata = {29'h0000_0000, s.sts_valid,
                    (s.irq != IRQ_IDLE), s.init_done};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // all control state resets; the enable freezes everything
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s <= '0;
            s.irq <= IRQ_IDLE;
            s.ctrl <= CTRL_RESET;
        end
        else if (CLK_EN)
        begin
            s <= n;
        end
    end

    // balance memory carries no reset and is cleared by the sweep instead
    always_ff @(posedge SYS_CLK)
    begin
        if (CLK_EN && mem_we)
        begin
            bal_mem[mem_addr] <= mem_data;
        end
    end

    assign CREDIT_GRANT_READY = s.grant_ready;
    assign FETCH_GRANT = s.fetch_grant;
    assign STS_EVT_READY = s.sts_ready;
    assign QUEUE_STATUS_VALID = s.sts_valid;
    assign QUEUE_STATUS = s.sts;
    assign USER_IRQ_ACKNOWLEDGE = s.ack;
    assign USER_IRQ_ABORT = s.fail;
    assign LINK_IRQ_VALID = s.link_valid;
    assign LINK_IRQ_VECTOR = s.link_vec;
    assign LINK_IRQ_FUNCTION = s.link_fnc;
    assign REG_RDATA = s.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking dcs_cb @(posedge SYS_CLK iff CLK_EN);
    endclocking
    default disable iff (!ARST_N);

    property p_grant_take;
        $rose(s.hold_v) |-> $past(CREDIT_GRANT_VALID && CREDIT_GRANT_READY);
    endproperty
    a_grant_take: assert property (p_grant_take) else $error("grant taken without handshake"); // R2

    property p_ready_blocked;
        s.hold_v || !s.init_done |-> !CREDIT_GRANT_READY;
    endproperty
    a_ready_blocked: assert property (p_ready_blocked) else $error("ready while busy"); // R2

    property p_fetch_nonzero;
        FETCH_GRANT |-> $past(fetch_bal) != 16'h0000 && $past(FETCH_REQ_VALID);
    endproperty
    a_fetch_nonzero: assert property (p_fetch_nonzero) else $error("fetch at zero"); // R6

    property p_fetch_take;
        // with no grant parked there is no merge, so the write is a plain decrement
        fetch_ok && !s.hold_v |=> bal_mem[$past(FETCH_REQ_RING)] == $past(fetch_bal) - 16'h0001;
    endproperty
    a_fetch_take: assert property (p_fetch_take) else $error("balance not decremented"); // R6

    property p_sts_hold;
        QUEUE_STATUS_VALID && !QUEUE_STATUS_READY |=> QUEUE_STATUS_VALID && $stable(QUEUE_STATUS);
    endproperty
    a_sts_hold: assert property (p_sts_hold) else $error("status dropped early"); // R7

    property p_sts_avail;
        sts_load |=> QUEUE_STATUS.queue_status_available ==
            ($past(STS_EVT.invalidated) ? $past(evt_bal) : $past(posted));
    endproperty
    a_sts_avail: assert property (p_sts_avail) else $error("wrong availability"); // R13

    property p_sts_overrun;
        sts_load |=> QUEUE_STATUS_VALID && QUEUE_STATUS.queue_status_overrun == $past(overrun);
    endproperty
    a_sts_overrun: assert property (p_sts_overrun) else $error("wrong overrun bit"); // R17

    property p_one_answer;
        (USER_IRQ_ACKNOWLEDGE || USER_IRQ_ABORT) |-> !(USER_IRQ_ACKNOWLEDGE && USER_IRQ_ABORT)
            ##1 !USER_IRQ_ACKNOWLEDGE && !USER_IRQ_ABORT;
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("double interrupt answer"); // R23

    property p_ack_cause;
        USER_IRQ_ACKNOWLEDGE |-> $past(LINK_IRQ_SENT && LINK_IRQ_VALID);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without send"); // R20

    property p_fail_vector;
        s.irq == IRQ_IDLE && USER_IRQ_REQUEST_VALID && USER_IRQ_VECTOR >= VEC_LIMIT
            |=> USER_IRQ_ABORT && !LINK_IRQ_VALID;
    endproperty
    a_fail_vector: assert property (p_fail_vector) else $error("bad vector not failed"); // R21

    c_grant: cover property (CREDIT_GRANT_VALID && CREDIT_GRANT_READY);
    c_status: cover property (QUEUE_STATUS_VALID && QUEUE_STATUS_READY);
    c_ack: cover property (USER_IRQ_ACKNOWLEDGE);
    c_fail: cover property (USER_IRQ_ABORT);

endmodule

// file: logic/dcs_pkg.sv
// shared constants and carrier types for the credit, status and interrupt ports
package dcs_pkg;
    localparam int RING_N = 4096;
    // ring direction codes for grants and status updates
    localparam logic DIR_HOST_TO_CARD = 1'b0;
    localparam logic DIR_CARD_TO_HOST = 1'b1;
    // per-function vector ceiling on the interrupt request port
    localparam logic [4:0] VEC_LIMIT = 5'h08;
    // register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PROBE = 4'h1;
    localparam logic [3:0] REG_BALANCE = 4'h2;
    localparam logic [3:0] REG_STATS = 4'h3;
    localparam logic [3:0] REG_STATE = 4'h4;
    // control field positions and reset value
    localparam int CTRL_FETCH_EN = 0;
    localparam int CTRL_IRQ_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    typedef logic [11:0] dcs_ring_t; // {direction, queue}

    typedef struct packed {
        logic queue_status_bypass_flag;
        logic queue_status_direction;
        logic queue_status_memory_mapped;
        logic [10:0] queue_status_queue;
        logic [15:0] queue_status_available;
        logic queue_status_invalidated;
        logic queue_status_enabled;
        logic queue_status_irq_armed;
        logic queue_status_overrun;
        logic [2:0] queue_status_port;
    } dcs_status_t;

    typedef struct packed {
        logic bypass;
        logic direction;
        logic memory_mapped;
        logic [10:0] queue;
        logic [15:0] old_producer_index;
        logic [15:0] new_producer_index;
        logic [15:0] consumer_index;
        logic invalidated;
        logic enabled;
        logic irq_armed;
        logic [2:0] port;
    } dcs_event_t;

    typedef enum logic [2:0] {
        IRQ_IDLE = 3'b001,
        IRQ_LINK = 3'b010,
        IRQ_RESP = 3'b100
    } dcs_irq_state_t;

    typedef struct packed {
        logic init_done;
        dcs_ring_t init_idx;
        logic grant_ready;
        logic hold_v;
        dcs_ring_t hold_ring;
        logic [15:0] hold_cnt;
        logic fetch_grant;
        logic sts_ready;
        logic sts_valid;
        dcs_status_t sts;
        dcs_irq_state_t irq;
        logic link_valid;
        logic [4:0] link_vec;
        logic [7:0] link_fnc;
        logic ack;
        logic fail;
        logic [1:0] ctrl;
        dcs_ring_t probe;
        logic [15:0] ack_cnt;
        logic [15:0] fail_cnt;
        logic [31:0] rdata;
    } dcs_state_t;
endpackage

// file: verification/dcs_link_model.sv
// link-side responder that answers forwarded interrupts after a chosen delay
`timescale 1ns/1ps
module dcs_link_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_valid,
    input wire logic [3:0] delay,
    input wire logic abort_mode,
    output logic sent,
    output logic aborted
);
    logic [3:0] cnt_q;
    logic done_q;
    ////////////////////////////////////////////////////////////////////////////////
    // one answer per forwarded request; re-arms only once the request drops,
    // so a request still standing after the answer is never answered twice
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            sent <= 1'b0;
            aborted <= 1'b0;
        end
        else if (!link_valid)
        begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            sent <= 1'b0;
            aborted <= 1'b0;
        end
        else if (!done_q && cnt_q == delay)
        begin
            sent <= !abort_mode;
            aborted <= abort_mode;
            done_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
            sent <= 1'b0;
            aborted <= 1'b0;
        end
    end
endmodule

// file: verification/dcs_user_ports_tb.sv
// self-checking bench for the credit, status and interrupt ports
`timescale 1ns/1ps
module dcs_user_ports_tb import dcs_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic gv = 1'b0, gdir = 1'b0, fv = 1'b0, ev = 1'b0, sr = 1'b0, iv = 1'b0;
    logic wr = 1'b0, rd = 1'b0, pabort = 1'b0, ce = 1'b1;
    logic [10:0] gq = 11'h000;
    logic [15:0] gc = 16'h0000;
    dcs_ring_t fring = 12'h000;
    dcs_event_t evt = '0;
    logic [4:0] ivec = 5'h00;
    logic [7:0] ifn = 8'h00;
    logic [3:0] addr = 4'h0, pdelay = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic grdy, fgrant, erdy, qv, ack, abt, lv, sent, abrt;
    dcs_status_t qs;
    logic [4:0] lvec;
    logic [7:0] lfn;
    int miscompares = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    // clock enable stays high except around one frozen register write
    dcs_user_ports DUT (.SYS_CLK(clk), .ARST_N(rst_n), .CLK_EN(ce),
        .CREDIT_GRANT_VALID(gv), .CREDIT_GRANT_READY(grdy), .CREDIT_GRANT_DIRECTION(gdir),
        .CREDIT_GRANT_QUEUE(gq), .CREDIT_GRANT_COUNT(gc), .FETCH_REQ_VALID(fv),
        .FETCH_REQ_RING(fring), .FETCH_GRANT(fgrant), .STS_EVT_VALID(ev), .STS_EVT(evt),
        .STS_EVT_READY(erdy), .QUEUE_STATUS_VALID(qv), .QUEUE_STATUS_READY(sr),
        .QUEUE_STATUS(qs), .USER_IRQ_REQUEST_VALID(iv), .USER_IRQ_VECTOR(ivec),
        .USER_IRQ_FUNCTION(ifn), .USER_IRQ_ACKNOWLEDGE(ack), .USER_IRQ_ABORT(abt),
        .LINK_IRQ_VALID(lv), .LINK_IRQ_VECTOR(lvec), .LINK_IRQ_FUNCTION(lfn),
        .LINK_IRQ_SENT(sent), .LINK_IRQ_ABORTED(abrt), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));

    dcs_link_model PARTNER (.clk(clk), .rst_n(rst_n), .link_valid(lv), .delay(pdelay),
        .abort_mode(pabort), .sent(sent), .aborted(abrt));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and report; wide enough for a whole status word
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // register port: one-cycle strobes, read data checked in the following cycle
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask

    // fields are valid with the strobe and held until ready has been seen high
    task automatic grant(input logic d, input logic [10:0] q, input logic [15:0] c);
        int n;
        n = 0;
        @(posedge clk);
        gv <= 1'b1;
        gdir <= d;
        gq <= q;
        gc <= c;
        @(negedge clk);
        while (grdy !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        gv <= 1'b0;
        chk(n < 100, 1'b1);
    endtask

    task automatic fetch(input dcs_ring_t r, input logic exp);
        @(posedge clk);
        fv <= 1'b1;
        fring <= r;
        @(posedge clk);
        fv <= 1'b0;
        @(negedge clk);
        chk(fgrant, exp);
    endtask

    // expected status word worked out from the event and the ring balance
    function automatic dcs_status_t exp_sts(input dcs_event_t e, input logic [15:0] bal);
        dcs_status_t s;
        logic [15:0] posted;
        posted = e.new_producer_index - e.old_producer_index;
        s = {e.bypass, e.direction, e.memory_mapped, e.queue, 16'h0000, e.invalidated,
            e.enabled, e.irq_armed, 1'b0, e.port};
        s.queue_status_available = e.invalidated ? bal : posted;
        s.queue_status_overrun = posted > (e.consumer_index - e.old_producer_index - 16'h0001);
        return s;
    endfunction

    // the update must stand unchanged while ready is held low, then clear
    task automatic status(input dcs_event_t e, input logic [15:0] bal);
        @(posedge clk);
        ev <= 1'b1;
        evt <= e;
        @(negedge clk);
        while (erdy !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        ev <= 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            chk({qv, qs}, {1'b1, exp_sts(e, bal)});
        end
        @(posedge clk);
        sr <= 1'b1;
        @(posedge clk);
        sr <= 1'b0;
        @(negedge clk);
        chk(qv, 1'b0);
    endtask

    // request held until one answer; forwarded vector and function checked once
    task automatic irq(input logic [4:0] v, input logic [7:0] f, input logic exp_ack);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(posedge clk);
        iv <= 1'b1;
        ivec <= v;
        ifn <= f;
        @(negedge clk);
        while (!(ack | abt) && n < 60)
        begin
            if (lv === 1'b1 && !seen)
            begin
                chk({lvec, lfn}, {v, f});
                seen = 1'b1;
            end
            @(negedge clk);
            n++;
        end
        chk({ack, abt}, {exp_ack, !exp_ack});
        @(posedge clk);
        iv <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        int n;
        n = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(REG_CTRL, 32'h0000_0003);
        reg_rd(4'hF, 32'h0000_0000);
        while (grdy !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        chk(grdy, 1'b1);
        reg_rd(REG_STATE, 32'h0000_0001);
        fetch({DIR_CARD_TO_HOST, 11'h005}, 1'b0);
        grant(DIR_CARD_TO_HOST, 11'h005, 16'h0002);
        grant(DIR_HOST_TO_CARD, 11'h005, 16'h0001);
        reg_wr(REG_PROBE, {20'h0, DIR_CARD_TO_HOST, 11'h005});
        reg_rd(REG_PROBE, {20'h0, DIR_CARD_TO_HOST, 11'h005});
        reg_rd(REG_BALANCE, 32'h0000_0002);
        reg_wr(REG_PROBE, {20'h0, DIR_HOST_TO_CARD, 11'h005});
        reg_rd(REG_BALANCE, 32'h0000_0001);
        // fetch enable cleared: a ring holding credit must still be refused
        reg_wr(REG_CTRL, 32'h0000_0002);
        fetch({DIR_HOST_TO_CARD, 11'h005}, 1'b0);
        reg_wr(REG_CTRL, 32'h0000_0003);
        fetch({DIR_CARD_TO_HOST, 11'h005}, 1'b1);
        status({1'b1, DIR_CARD_TO_HOST, 1'b0, 11'h005, 16'h000A, 16'h000A, 16'h0014, 1'b1, 1'b1,
            1'b0, 3'h2}, 16'h0001);
        fetch({DIR_CARD_TO_HOST, 11'h005}, 1'b1);
        fetch({DIR_CARD_TO_HOST, 11'h005}, 1'b0);
        status({1'b0, DIR_HOST_TO_CARD, 1'b1, 11'h7FF, 16'h000A, 16'h0013, 16'h0014, 1'b0, 1'b0,
            1'b1, 3'h5}, 16'h0000);
        status({1'b1, DIR_CARD_TO_HOST, 1'b1, 11'h000, 16'hFFFA, 16'h001E, 16'h0004, 1'b0, 1'b1,
            1'b1, 3'h7}, 16'h0000);
        // ready tied high as for an unused port: each update stands one cycle
        @(posedge clk);
        sr <= 1'b1;
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        @(negedge clk);
        chk(qv, 1'b1);
        @(negedge clk);
        chk({qv, erdy}, 2'b01);
        @(posedge clk);
        sr <= 1'b0;
        pdelay <= 4'h0;
        irq(5'h03, 8'h02, 1'b1);
        pdelay <= 4'h6;
        irq(5'h07, 8'h11, 1'b1);
        pabort <= 1'b1;
        irq(5'h05, 8'hFF, 1'b0);
        pabort <= 1'b0;
        irq(5'h08, 8'h01, 1'b0);
        reg_wr(REG_CTRL, 32'h0000_0001);
        irq(5'h01, 8'h01, 1'b0);
        reg_wr(REG_CTRL, 32'h0000_0003);
        reg_rd(REG_STATS, 32'h0003_0002);
        // a write while the enable is low must leave the counts alone
        @(posedge clk);
        ce <= 1'b0;
        reg_wr(REG_STATS, 32'h0000_0000);
        ce <= 1'b1;
        reg_rd(REG_STATS, 32'h0003_0002);
        reg_wr(REG_STATS, 32'h0000_0000);
        reg_rd(REG_STATS, 32'h0000_0000);
        wrap_up();
    end

    // watchdog: the run needs well under ten thousand cycles
    initial
    begin
        #(20 * 10000);
        miscompares++;
        wrap_up();
    end
endmodule
